// File: logic/smm_range_and_memory_routing.sv
`timescale 1ns/1ps
module smm_range_and_memory_routing
    import smm_route_pkg::*;
#(
    parameter int PEND_W = 7
) (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // CPU memory request path
    input  wire logic              req_valid,
    input  wire mem_req_s          req,
    output mem_route_s             route,
    // Refresh arbitration
    input  wire logic              refresh_trigger,
    input  wire logic              refresh_serviced,
    output logic      [PEND_W-1:0] refresh_pending,
    output logic                   refresh_top_priority,
    output logic                   reorder_enable
);

    // =====================================================
    // Decode helpers
    // =====================================================
    function automatic logic in_range(input logic [31:0] a,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [31:0] read_word(input logic [11:0] a,
                                              input logic [7:0]  rr,
                                              input logic [7:0]  ctl,
                                              input logic [31:0] att);
        logic [31:0] w;
        w = 32'h00000000;
        case (a)
            ADDR_REORDER: w = {24'h000000, rr};
            ADDR_CTRL:    w = {24'h000000, ctl};
            ADDR_ATTR:    w = att;
            default:      w = 32'h00000000;
        endcase
        return w;
    endfunction

    // Legacy window decision for an access that already hit the window
    function automatic logic win_to_sdram(input logic [7:0] ctl,
                                          input logic       wr,
                                          input logic       code,
                                          input logic       smm_n);
        logic         en;
        access_mode_e mode;
        en   = wr ? ctl[WR_EN_BIT] : ctl[RD_EN_BIT];
        mode = access_mode_e'(ctl[MODE_LSB +: 2]);
        if (!en) begin
            return 1'b0;
        end
        if (smm_n) begin
            return mode == MODE_OPEN;
        end
        case (mode)
            MODE_OPEN, MODE_PROTECTED: return 1'b1;
            MODE_CLOSED, MODE_LOCKED:  return code;
            default:                   return 1'b0;
        endcase
    endfunction

    // Shadow region C0000h-FFFFFh: 16KB fields below F0000h, one 64KB above
    function automatic logic shadow_to_sdram(input logic [31:0] att,
                                             input logic [31:0] a,
                                             input logic        wr);
        logic [3:0] idx;
        logic [1:0] fld;
        idx = (a >= SHADOW_TOP) ? ATTR_TOP_IDX : a[17:14];
        fld = att[ATTR_LSB + 2 * int'(idx) +: 2];
        return wr ? fld[1] : fld[0];
    endfunction

    // =====================================================
    // AHB-Lite address and data phase
    // =====================================================
    logic              addr_phase;
    logic              dp_write_r;
    logic [ADDR_W-1:0] dp_addr_r;

    assign addr_phase = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_r <= 1'b0;
            dp_addr_r  <= '0;
        end else begin
            dp_write_r <= addr_phase && hwrite;
            if (addr_phase) begin
                dp_addr_r <= haddr;
            end
        end
    end

    // =====================================================
    // Registers
    // =====================================================
    logic [7:0]  reorder_r;
    logic [7:0]  reorder_nxt;
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [31:0] attr_r;
    logic [31:0] attr_nxt;

    always_comb begin
        reorder_nxt = reorder_r;
        ctrl_nxt    = ctrl_r;
        attr_nxt    = attr_r;
        if (dp_write_r) begin
            case (dp_addr_r)
                ADDR_REORDER: reorder_nxt = hwdata[7:0] & REORDER_WMASK;
                ADDR_CTRL:    ctrl_nxt    = hwdata[7:0] & CTRL_WMASK;
                ADDR_ATTR:    attr_nxt    = hwdata & ATTR_WMASK;
                default:      ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reorder_r <= RST_REORDER;
            ctrl_r    <= RST_CTRL;
            attr_r    <= RST_ATTR;
        end else begin
            reorder_r <= reorder_nxt;
            ctrl_r    <= ctrl_nxt;
            attr_r    <= attr_nxt;
        end
    end

    assign reorder_enable = reorder_r[REORDER_EN_BIT];

    // Read data comes from the next values so that a read right behind
    // a write to the same register sees the new contents.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
            if (addr_phase && !hwrite) begin
                hrdata <= read_word(haddr, reorder_nxt, ctrl_nxt, attr_nxt);
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    // =====================================================
    // Refresh bookkeeping
    // =====================================================
    logic [PEND_W-1:0] pending_nxt;
    logic [PEND_W-1:0] threshold;

    assign threshold = PEND_W'(reorder_nxt[THR_LSB +: THR_W]);

    // Saturates both ways; a trigger and a service together cancel
    always_comb begin
        pending_nxt = refresh_pending;
        case ({refresh_trigger, refresh_serviced})
            2'b10: begin
                if (refresh_pending != {PEND_W{1'b1}}) begin
                    pending_nxt = refresh_pending + 1'b1;
                end
            end
            2'b01: begin
                if (refresh_pending != '0) begin
                    pending_nxt = refresh_pending - 1'b1;
                end
            end
            default: pending_nxt = refresh_pending;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refresh_pending      <= '0;
            refresh_top_priority <= 1'b0;
        end else begin
            refresh_pending      <= pending_nxt;
            refresh_top_priority <= pending_nxt > threshold;
        end
    end

    // =====================================================
    // Request routing
    // =====================================================
    logic [31:0] eff_addr;
    logic        eff_sdram;

    always_comb begin
        eff_addr = req.addr;
        if (!req.sysmgmt_request_indication_n && ctrl_r[REMAP_BIT] &&
            in_range(req.addr, REMAP_LO, REMAP_HI)) begin
            eff_addr = req.addr - REMAP_LO + WIN_LO;
        end
        // Plain memory outside the decoded ranges stays on SDRAM
        if (in_range(eff_addr, WIN_LO, WIN_HI)) begin
            eff_sdram = win_to_sdram(ctrl_r, req.write, req.code,
                                     req.sysmgmt_request_indication_n);
        end else if (in_range(eff_addr, SHADOW_LO, SHADOW_HI)) begin
            eff_sdram = shadow_to_sdram(attr_r, eff_addr, req.write);
        end else begin
            eff_sdram = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            route <= '0;
        end else begin
            route.valid <= req_valid;
            if (req_valid) begin
                route.to_sdram <= eff_sdram;
                route.addr     <= eff_addr;
            end
        end
    end

    // =====================================================
    // Checks
    // =====================================================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_reorder_bit;
        dp_write_r && dp_addr_r == ADDR_REORDER
            |=> reorder_enable == $past(hwdata[REORDER_EN_BIT]);
    endproperty
    a_reorder_bit: assert property (p_reorder_bit)
        else $error("reorder enable did not follow write");

    property p_pending_count;
        refresh_trigger && !refresh_serviced &&
        refresh_pending != {PEND_W{1'b1}}
            |=> refresh_pending == $past(refresh_pending) + 1'b1;
    endproperty
    a_pending_count: assert property (p_pending_count)
        else $error("pending refresh count did not rise");

    property p_top_priority;
        refresh_top_priority ==
            (refresh_pending > PEND_W'(reorder_r[THR_LSB +: THR_W]));
    endproperty
    a_top_priority: assert property (p_top_priority)
        else $error("refresh priority disagrees with threshold");

    property p_read_disabled;
        req_valid && !req.write && in_range(req.addr, WIN_LO, WIN_HI) &&
        !ctrl_r[RD_EN_BIT] |=> route.valid && !route.to_sdram;
    endproperty
    a_read_disabled: assert property (p_read_disabled)
        else $error("disabled window read not sent to PCI");

    property p_write_disabled;
        req_valid && req.write && in_range(req.addr, WIN_LO, WIN_HI) &&
        !ctrl_r[WR_EN_BIT] |=> route.valid && !route.to_sdram;
    endproperty
    a_write_disabled: assert property (p_write_disabled)
        else $error("disabled window write not sent to PCI");

    property p_non_smm_mode;
        req_valid && !req.write && in_range(req.addr, WIN_LO, WIN_HI) &&
        ctrl_r[RD_EN_BIT] && req.sysmgmt_request_indication_n
            |=> route.to_sdram ==
                $past(ctrl_r[MODE_LSB +: 2] == MODE_OPEN);
    endproperty
    a_non_smm_mode: assert property (p_non_smm_mode)
        else $error("non-SMM window access routed wrongly");

    property p_smm_closed;
        req_valid && !req.write && in_range(req.addr, WIN_LO, WIN_HI) &&
        ctrl_r[RD_EN_BIT] && !req.sysmgmt_request_indication_n &&
        !ctrl_r[MODE_LSB] |=> route.to_sdram == $past(req.code);
    endproperty
    a_smm_closed: assert property (p_smm_closed)
        else $error("SMM closed/locked access routed wrongly");

    property p_smm_open;
        req_valid && in_range(req.addr, WIN_LO, WIN_HI) &&
        !req.sysmgmt_request_indication_n && ctrl_r[MODE_LSB] &&
        (req.write ? ctrl_r[WR_EN_BIT] : ctrl_r[RD_EN_BIT])
            |=> route.to_sdram;
    endproperty
    a_smm_open: assert property (p_smm_open)
        else $error("SMM open/protected access not sent to SDRAM");

    property p_remap;
        req_valid && !req.sysmgmt_request_indication_n &&
        ctrl_r[REMAP_BIT] && in_range(req.addr, REMAP_LO, REMAP_HI)
            |=> route.addr == $past(req.addr) - REMAP_LO + WIN_LO;
    endproperty
    a_remap: assert property (p_remap)
        else $error("SMM default range not remapped");

    property p_no_remap;
        req_valid && !ctrl_r[REMAP_BIT] |=> route.addr == $past(req.addr);
    endproperty
    a_no_remap: assert property (p_no_remap)
        else $error("address changed with remap off");

    property p_shadow_top;
        req_valid && in_range(req.addr, SHADOW_TOP, SHADOW_HI) &&
        attr_r[29:28] == 2'b01
            |=> route.to_sdram == !$past(req.write);
    endproperty
    a_shadow_top: assert property (p_shadow_top)
        else $error("top shadow region routed wrongly");

    property p_attr_reserved;
        attr_r[31:30] == 2'b00 && attr_r[3:0] == 4'h0;
    endproperty
    a_attr_reserved: assert property (p_attr_reserved)
        else $error("reserved shadow bits not zero");

endmodule

// File: logic/smm_route_pkg.sv
package smm_route_pkg;

    // =====================================================
    // Register map: printed offsets are word indexes
    // =====================================================
    localparam int          ADDR_W         = 12;
    localparam logic [7:0]  IDX_REORDER    = 8'h6e;
    localparam logic [7:0]  IDX_CTRL       = 8'h83;
    localparam logic [7:0]  IDX_ATTR       = 8'h84;
    localparam logic [11:0] ADDR_REORDER   = {2'b00, IDX_REORDER, 2'b00};
    localparam logic [11:0] ADDR_CTRL      = {2'b00, IDX_CTRL, 2'b00};
    localparam logic [11:0] ADDR_ATTR      = {2'b00, IDX_ATTR, 2'b00};

    // =====================================================
    // Reset values and writable-bit masks
    // =====================================================
    localparam logic [7:0]  RST_REORDER    = 8'h00;
    localparam logic [7:0]  RST_CTRL       = 8'h08;
    localparam logic [31:0] RST_ATTR       = 32'h00000000;
    localparam logic [7:0]  REORDER_WMASK  = 8'hbf;
    localparam logic [7:0]  CTRL_WMASK     = 8'hf8;
    localparam logic [31:0] ATTR_WMASK     = 32'h3ffffff0;

    // =====================================================
    // Field positions
    // =====================================================
    localparam int          REORDER_EN_BIT = 7;
    localparam int          THR_LSB        = 0;
    localparam int          THR_W          = 6;
    localparam int          RD_EN_BIT      = 7;
    localparam int          WR_EN_BIT      = 6;
    localparam int          MODE_LSB       = 4;
    localparam int          REMAP_BIT      = 3;
    localparam int          ATTR_LSB       = 4;
    localparam int          ATTR_REGIONS   = 13;
    localparam logic [3:0]  ATTR_TOP_IDX   = 4'hc;

    // =====================================================
    // Address ranges
    // =====================================================
    localparam logic [31:0] WIN_LO         = 32'h000a0000;
    localparam logic [31:0] WIN_HI         = 32'h000bffff;
    localparam logic [31:0] REMAP_LO       = 32'h00038000;
    localparam logic [31:0] REMAP_HI       = 32'h0003ffff;
    localparam logic [31:0] SHADOW_LO      = 32'h000c0000;
    localparam logic [31:0] SHADOW_TOP     = 32'h000f0000;
    localparam logic [31:0] SHADOW_HI      = 32'h000fffff;

    localparam logic        HRESP_OKAY     = 1'b0;

    typedef enum logic [1:0] {
        MODE_CLOSED    = 2'b00,
        MODE_OPEN      = 2'b01,
        MODE_LOCKED    = 2'b10,
        MODE_PROTECTED = 2'b11
    } access_mode_e;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic        code;
        logic        sysmgmt_request_indication_n;
    } mem_req_s;

    typedef struct packed {
        logic        valid;
        logic        to_sdram;
        logic [31:0] addr;
    } mem_route_s;

endpackage

// File: tb/cpu_req_model.sv
`timescale 1ns/1ps
// ==========
// CPU request source
// ==========
module cpu_req_model
    import smm_route_pkg::*;
(
    // Clock
    input  wire logic hclk,
    // Request path
    output logic      req_valid,
    output mem_req_s  req
);
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end

    // One request per edge; caller must sit on a rising edge
    task automatic send(input mem_req_s r);
        req_valid <= 1'b1;
        req       <= r;
        @(posedge hclk);
    endtask

    // Idle fields carry garbage so a stale request is never trusted
    task automatic idle();
        req_valid <= 1'b0;
        req       <= ~req;
    endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
    import smm_route_pkg::*;
    logic              hclk    = 1'b0;
    logic              hresetn = 1'b0;
    logic              hsel    = 1'b0;
    logic              hwrite  = 1'b0;
    logic [ADDR_W-1:0] haddr   = '0;
    logic [1:0]        htrans  = '0;
    logic [2:0]        hsize   = 3'h2;
    logic [31:0]       hwdata  = '0;
    logic [31:0]       hrdata;
    logic              hready;
    logic              hreadyout;
    logic              hresp;
    logic              req_valid;
    mem_req_s          req;
    mem_route_s        route;
    logic              trg     = 1'b0;
    logic              srv     = 1'b0;
    logic [6:0]        pend;
    logic              topp;
    logic              reoe;
    int                failures = 0;
    int                checked  = 0;
    int                cnt;
    logic [33:0]       rq[$];
    logic [31:0]       bq[$];
    logic [33:0]       e;
    logic [33:0]       rt;
    logic              rd_ph   = 1'b0;
    logic [7:0]        ctl_m   = RST_CTRL;
    logic [31:0]       att_m   = RST_ATTR;
    mem_req_s          r;
    logic [31:0]       tbl[12] = '{32'h000a0000, 32'h000bffff,
        32'h0009ffff, 32'h00038000, 32'h0003ffff, 32'h00037fff,
        32'h000c0000, 32'h000c7fff, 32'h000ec000, 32'h000f0000,
        32'h000fffff, 32'h00100000};
    logic [11:0]       radr[4] = '{ADDR_REORDER, ADDR_CTRL, ADDR_ATTR,
        12'h004};
    logic [31:0]       rmsk[4] = '{{24'h0, REORDER_WMASK},
        {24'h0, CTRL_WMASK}, ATTR_WMASK, 32'h0};

    always #10 hclk = ~hclk;
    assign hready = hreadyout;
    assign rt     = {1'b0, route.to_sdram, route.addr};

    smm_range_and_memory_routing dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid),
        .req(req), .route(route), .refresh_trigger(trg),
        .refresh_serviced(srv), .refresh_pending(pend),
        .refresh_top_priority(topp), .reorder_enable(reoe));

    cpu_req_model cpu (.hclk(hclk), .req_valid(req_valid), .req(req));

    // ==========
    // Expected routing
    // ==========
    function automatic logic [33:0] exp_route(mem_req_s q);
        logic [31:0] a;
        logic        en;
        logic        sd;
        logic [1:0]  f;
        int          i;
        a = q.addr;
        if (ctl_m[3] && !q.sysmgmt_request_indication_n &&
            a >= REMAP_LO && a <= REMAP_HI) a = a - REMAP_LO + WIN_LO;
        sd = 1'b1;
        if (a >= WIN_LO && a <= WIN_HI) begin
            en = q.write ? ctl_m[6] : ctl_m[7];
            if (q.sysmgmt_request_indication_n)
                sd = en && ctl_m[5:4] == MODE_OPEN;
            else
                sd = en && (ctl_m[4] || q.code);
        end else if (a >= SHADOW_LO && a <= SHADOW_HI) begin
            i = (a >= SHADOW_TOP) ? 12 : int'(a[17:14]);
            f = att_m[4 + 2 * i +: 2];
            sd = q.write ? f[1] : f[0];
        end
        return {1'b0, sd, a};
    endfunction

    // ==========
    // Bus master
    // ==========
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) begin
            failures++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        if (a == ADDR_CTRL) ctl_m = d[7:0] & CTRL_WMASK;
        if (a == ADDR_ATTR) att_m = d & ATTR_WMASK;
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        bq.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0 && rq.size() == 0 &&
            bq.size() == 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========
    // Output monitor
    // ==========
    always @(posedge hclk) begin
        if (route.valid === 1'b1) begin
            e = rq.size() ? rq.pop_front() : 'x;
            `CHK("route", e, rt)
        end
        if (rd_ph) begin
            e = {1'b0, HRESP_OKAY, bq.size() ? bq.pop_front() : 'x};
            `CHK("read", e, {1'b0, hresp, hrdata})
        end
        rd_ph <= hsel && htrans[1] && !hwrite && hready;
    end

    // ==========
    // Main sequence
    // ==========
    initial begin
        void'($urandom(32'ha544));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(ADDR_REORDER, {24'h0, RST_REORDER});
        rd(ADDR_CTRL, {24'h0, RST_CTRL});
        rd(ADDR_ATTR, RST_ATTR);
        for (int k = 0; k < 4; k++) begin
            wr(radr[k], 32'hffffffff);
            rd(radr[k], rmsk[k]);
        end
        @(posedge hclk);
        `CHK("reorder_enable", 1'b1, reoe)
        $display("test registers done");

        wr(ADDR_REORDER, 32'h00000003);
        @(posedge hclk);
        `CHK("reorder_enable", 1'b0, reoe)
        cnt = 0;
        for (int k = 0; k < 40; k++) begin
            trg <= ($urandom_range(0, 3) != 0);
            srv <= 1'($urandom_range(0, 1));
            @(posedge hclk);
            if (trg && !srv && cnt < 127) cnt++;
            else if (srv && !trg && cnt > 0) cnt--;
            trg <= 1'b0;
            srv <= 1'b0;
            @(negedge hclk);
            `CHK("pending", 7'(cnt), pend)
            `CHK("top_priority", 1'(cnt > 3), topp)
            @(posedge hclk);
        end
        $display("test refresh done");

        // Every enable, mode and remap combination, requests back to back
        for (int c = 0; c < 32; c++) begin
            wr(ADDR_CTRL, {24'h0, c[4:0], 3'b000});
            wr(ADDR_ATTR, $urandom);
            repeat (6) begin
                r = {tbl[$urandom_range(0, 11)], 3'($urandom)};
                rq.push_back(exp_route(r));
                cpu.send(r);
            end
            cpu.idle();
        end
        repeat (3) @(posedge hclk);
        $display("test routing done");
        stop_test();
    end
endmodule
